// ===== inc/spi_flags_pkg.sv
package spi_flags_pkg;

	localparam int ADDR_W = 4;
	localparam int DATA_W = 8;
	localparam int FIELD_W = 3;
	localparam int HALF_W = 11;

	// register offsets on the plain register port
	localparam logic [3:0] OFS_CTRL1 = 4'h0;
	localparam logic [3:0] OFS_CTRL2 = 4'h1;
	localparam logic [3:0] OFS_BAUD = 4'h2;
	localparam logic [3:0] OFS_STATUS = 4'h3;
	localparam logic [3:0] OFS_DATA = 4'h5;
	localparam logic [3:0] OFS_EVT = 4'h6;
	localparam logic [3:0] OFS_EVT_CLR = 4'h7;
	localparam logic [3:0] OFS_EVT_EN = 4'h8;

	// field positions
	localparam int BIT_RXC = 7;
	localparam int BIT_TXE = 5;
	localparam int BIT_MODE_FAULT_FLAG = 4;
	localparam int BIT_IRQ_EN = 7;
	localparam int BIT_PORT_EN = 6;
	localparam int BIT_MASTER = 4;
	localparam int BIT_MODE_FAULT_FLAG_EN = 4;
	localparam int PRE_LSB = 4;
	localparam int SEL_LSB = 0;

	// reset values and write masks
	localparam logic [7:0] CTRL1_RST = 8'h00;
	localparam logic [7:0] CTRL2_RST = 8'h00;
	localparam logic [7:0] BAUD_RST = 8'h00;
	localparam logic [7:0] EVT_EN_RST = 8'hB0;
	localparam logic [7:0] CTRL1_MASK = 8'hD0;
	localparam logic [7:0] CTRL2_MASK = 8'h10;
	localparam logic [7:0] BAUD_MASK = 8'h77;

	// counts per byte
	localparam logic [4:0] LAST_EDGE = 5'h0F;
	localparam logic [2:0] LAST_BIT = 3'h7;

	typedef enum logic [1:0]
	{
		ST_IDLE = 2'b00,
		ST_RUN = 2'b01,
		ST_DONE = 2'b11
	} xfer_st_t;

	// half of the divisor (pre+1)*2^(sel+1), in bus clocks
	function automatic logic [HALF_W-1:0] half_period(input logic [FIELD_W-1:0] pre, input logic [FIELD_W-1:0] sel);
		logic [HALF_W-1:0] p;
		p = {8'h00, pre} + 11'h001;
		return p << sel;
	endfunction

endpackage

// ===== verilog/pin_filter.sv
`timescale 1ns/10ps
`default_nettype none
module pin_filter #(
	parameter int W = 4,
	parameter logic [W-1:0] RST_VAL = '0
)
(
	input wire logic clk,
	input wire logic rstn,
	input wire logic [W-1:0] pin,
	output var logic [W-1:0] level
);

	logic [W-1:0] s1_r;
	logic [W-1:0] s2_r;
	logic [W-1:0] s3_r;
	logic [W-1:0] level_nxt;

	// a bit moves only once the second and third stages agree
	assign level_nxt = (level & (s2_r ^ s3_r)) | (s2_r & ~(s2_r ^ s3_r));

	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			s1_r <= RST_VAL;
			s2_r <= RST_VAL;
			s3_r <= RST_VAL;
			level <= RST_VAL;
		end
		else
		begin
			s1_r <= pin;
			s2_r <= s1_r;
			s3_r <= s2_r;
			level <= level_nxt;
		end
	end

endmodule
`default_nettype wire

// ===== verilog/baud_divider.sv
`timescale 1ns/10ps
`default_nettype none
module baud_divider
	import spi_flags_pkg::*;
(
	input wire logic clk,
	input wire logic rstn,
	input wire logic run,
	input wire logic [spi_flags_pkg::FIELD_W-1:0] pre,
	input wire logic [spi_flags_pkg::FIELD_W-1:0] sel,
	output var logic tick
);

	logic [HALF_W-1:0] cnt_r;
	logic [HALF_W-1:0] half;
	logic wrap;

	assign half = half_period(pre, sel);
	assign wrap = (cnt_r == half - 11'h001);

	// one tick per half serial clock, so two ticks span the whole divisor RQ11
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			cnt_r <= '0;
			tick <= 1'b0;
		end
		else if (!run)
		begin
			cnt_r <= '0;
			tick <= 1'b0;
		end
		else
		begin
			cnt_r <= wrap ? '0 : cnt_r + 11'h001; // RQ12
			tick <= wrap; // RQ1
		end
	end

endmodule
`default_nettype wire

// ===== verilog/spi_baud_and_status_flags.sv
// Functional notes
// RQ1: divider gives serial clock divisors from 2 up to 2048 of the bus clock.
// RQ2: an outside master must never clock a slave at half the bus rate.
// RQ3: status register reads anytime; writing it changes nothing.
// RQ4: bit 7 sets once a received byte lands in the data register.
// RQ5: bit 7 clears on status read seeing it set, then data read.
// RQ6: bit 5 reads one while transmit buffer empty, zero while holding data.
// RQ7: status read seeing bit 5 set, then data write, loads byte, clears.
// RQ8: data writes without that preceding status read are ignored.
// RQ9: bit 4 sets when select input drops low in master with detection on.
// RQ10: bit 4 clears on status read seeing it, then first control write.
// RQ11: divisor is (preselect plus one) times two to (select plus one).
// RQ12: serial clock rate is bus clock over the divisor.
// RQ13: master divisor field change aborts any transfer and returns idle.
// RQ14: mode fault with interrupt enable set requests an interrupt.
// RQ15: status bits without a flag read as zero.
//
// Decided for this implementation: strobed register access and the register offsets.
`timescale 1ns/10ps
`default_nettype none
module spi_baud_and_status_flags
(
	input wire logic CORE_CLK,
	input wire logic RSTN,
	input wire logic [spi_flags_pkg::ADDR_W-1:0] ADDR,
	input wire logic [spi_flags_pkg::DATA_W-1:0] WDATA,
	input wire logic WR,
	input wire logic RD,
	output var logic [spi_flags_pkg::DATA_W-1:0] RDATA,
	output var logic IRQ,
	output var logic SCK_O,
	output var logic SCK_OE,
	input wire logic SCK_I,
	output var logic MOSI_O,
	output var logic MOSI_OE,
	input wire logic MOSI_I,
	output var logic MISO_O,
	output var logic MISO_OE,
	input wire logic MISO_I,
	input wire logic SS_N_I
);
	import spi_flags_pkg::*;

	////////////////////////////////////////////////////////////////////////////
	// storage

	logic [7:0] ctrl1_r;
	logic [7:0] ctrl2_r;
	logic [7:0] baud_r;
	logic rx_flag_r;
	logic tx_empty_r;
	logic mode_fault_flag_r;
	logic rx_arm_r;
	logic tx_arm_r;
	logic mode_fault_flag_arm_r;
	logic [7:0] tx_buf_r;
	logic [7:0] rx_buf_r;
	logic [7:0] shift_r;
	logic samp_r;
	logic [4:0] edge_cnt_r;
	logic [2:0] bit_cnt_r;
	logic slv_loaded_r;
	logic sck_d_r;
	xfer_st_t st_r;
	logic [7:0] evt_r;
	logic [7:0] evt_en_r;

	////////////////////////////////////////////////////////////////////////////
	// pins and divider

	logic [3:0] pins_s;
	logic sck_s;
	logic mosi_s;
	logic miso_s;
	logic ss_n_s;
	logic tick;

	pin_filter #(.W(4), .RST_VAL(4'h8)) u_pins
	(
		.clk(CORE_CLK),
		.rstn(RSTN),
		.pin({SS_N_I, MISO_I, MOSI_I, SCK_I}),
		.level(pins_s)
	);

	assign sck_s = pins_s[0];
	assign mosi_s = pins_s[1];
	assign miso_s = pins_s[2];
	assign ss_n_s = pins_s[3];

	logic [FIELD_W-1:0] pre;
	logic [FIELD_W-1:0] sel;
	logic m_running;

	assign pre = baud_r[PRE_LSB +: FIELD_W];
	assign sel = baud_r[SEL_LSB +: FIELD_W];
	assign m_running = (st_r == ST_RUN);

	baud_divider u_div
	(
		.clk(CORE_CLK),
		.rstn(RSTN),
		.run(m_running),
		.pre(pre),
		.sel(sel),
		.tick(tick)
	);

	////////////////////////////////////////////////////////////////////////////
	// decode

	logic wr_c1;
	logic wr_c2;
	logic wr_baud;
	logic wr_data;
	logic wr_evt_clr;
	logic wr_evt_en;
	logic rd_stat;
	logic rd_data;
	logic master;
	logic port_en;
	logic baud_chg;
	logic mode_fault_flag_hit;
	logic m_abort;
	logic tx_load;

	assign wr_c1 = WR & (ADDR == OFS_CTRL1);
	assign wr_c2 = WR & (ADDR == OFS_CTRL2);
	assign wr_baud = WR & (ADDR == OFS_BAUD);
	assign wr_data = WR & (ADDR == OFS_DATA);
	assign wr_evt_clr = WR & (ADDR == OFS_EVT_CLR);
	assign wr_evt_en = WR & (ADDR == OFS_EVT_EN);
	assign rd_stat = RD & (ADDR == OFS_STATUS);
	assign rd_data = RD & (ADDR == OFS_DATA);
	assign master = ctrl1_r[BIT_MASTER];
	assign port_en = ctrl1_r[BIT_PORT_EN];
	assign baud_chg = wr_baud & (((WDATA ^ baud_r) & BAUD_MASK) != 8'h00);
	assign mode_fault_flag_hit = port_en & master & ctrl2_r[BIT_MODE_FAULT_FLAG_EN] & ~ss_n_s; // RQ9
	assign m_abort = (master & baud_chg) | mode_fault_flag_hit | ~port_en | ~master; // RQ13
	assign tx_load = wr_data & tx_arm_r; // RQ7 RQ8

	logic [7:0] status_val;

	always_comb
	begin
		status_val = 8'h00; // RQ15
		status_val[BIT_RXC] = rx_flag_r;
		status_val[BIT_TXE] = tx_empty_r; // RQ6
		status_val[BIT_MODE_FAULT_FLAG] = mode_fault_flag_r;
	end

	logic [7:0] rd_mux;

	assign rd_mux = (ADDR == OFS_CTRL1) ? ctrl1_r :
		(ADDR == OFS_CTRL2) ? ctrl2_r :
		(ADDR == OFS_BAUD) ? baud_r :
		(ADDR == OFS_STATUS) ? status_val : // RQ3
		(ADDR == OFS_DATA) ? rx_buf_r :
		(ADDR == OFS_EVT) ? evt_r :
		(ADDR == OFS_EVT_EN) ? evt_en_r : 8'h00;

	////////////////////////////////////////////////////////////////////////////
	// control registers; the status offset has no write path at all

	always_ff @(posedge CORE_CLK or negedge RSTN)
	begin
		if (!RSTN)
		begin
			ctrl1_r <= CTRL1_RST;
			ctrl2_r <= CTRL2_RST;
			baud_r <= BAUD_RST;
			evt_en_r <= EVT_EN_RST;
			RDATA <= 8'h00;
		end
		else
		begin
			if (mode_fault_flag_hit)
				ctrl1_r <= ctrl1_r & ~(8'h01 << BIT_MASTER);
			else if (wr_c1)
				ctrl1_r <= WDATA & CTRL1_MASK;
			if (wr_c2)
				ctrl2_r <= WDATA & CTRL2_MASK;
			if (wr_baud)
				baud_r <= WDATA & BAUD_MASK;
			if (wr_evt_en)
				evt_en_r <= WDATA & EVT_EN_RST;
			RDATA <= RD ? rd_mux : 8'h00;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// shift engine: master runs off the divider, slave off the filtered pins

	logic m_take;
	logic s_take;
	logic byte_done;
	logic [7:0] byte_in;
	logic sck_rise;
	logic sck_fall;
	logic s_active;

	assign m_take = (st_r == ST_IDLE) & ~tx_empty_r & ~m_abort;
	assign s_active = port_en & ~master & ~ss_n_s;
	assign s_take = s_active & ~slv_loaded_r;
	assign sck_rise = sck_s & ~sck_d_r;
	assign sck_fall = ~sck_s & sck_d_r;

	// slave completes on its eighth sampling edge, master in the done state
	assign byte_done = (st_r == ST_DONE) | (s_active & slv_loaded_r & sck_rise & (bit_cnt_r == LAST_BIT));
	assign byte_in = (st_r == ST_DONE) ? shift_r : {shift_r[6:0], mosi_s};

	always_ff @(posedge CORE_CLK or negedge RSTN)
	begin
		if (!RSTN)
		begin
			st_r <= ST_IDLE;
			shift_r <= 8'h00;
			samp_r <= 1'b0;
			edge_cnt_r <= 5'h00;
			SCK_O <= 1'b0;
			MOSI_O <= 1'b0;
		end
		else
		begin
			case (st_r)
				ST_IDLE:
				begin
					edge_cnt_r <= 5'h00;
					SCK_O <= 1'b0;
					if (m_take)
					begin
						st_r <= ST_RUN;
						shift_r <= tx_buf_r;
						MOSI_O <= tx_buf_r[7];
					end
				end
				ST_RUN:
				begin
					if (m_abort)
					begin
						st_r <= ST_IDLE; // RQ13
						SCK_O <= 1'b0;
					end
					else if (tick)
					begin
						edge_cnt_r <= edge_cnt_r + 5'h01;
						SCK_O <= ~edge_cnt_r[0];
						if (!edge_cnt_r[0])
							samp_r <= miso_s;
						else
						begin
							shift_r <= {shift_r[6:0], samp_r};
							MOSI_O <= shift_r[6];
						end
						if (edge_cnt_r == LAST_EDGE)
							st_r <= ST_DONE;
					end
				end
				ST_DONE:
					st_r <= ST_IDLE;
				default:
					st_r <= ST_IDLE;
			endcase
			if (s_take)
				shift_r <= tx_empty_r ? 8'h00 : tx_buf_r;
			else if (s_active && sck_rise)
				samp_r <= mosi_s;
			else if (s_active && sck_fall)
				shift_r <= {shift_r[6:0], samp_r};
		end
	end

	// slave bit counter and data-out pin; deselect clears the bit counter and load flag, MISO_O keeps its value
	always_ff @(posedge CORE_CLK or negedge RSTN)
	begin
		if (!RSTN)
		begin
			bit_cnt_r <= 3'h0;
			slv_loaded_r <= 1'b0;
			sck_d_r <= 1'b0;
			MISO_O <= 1'b0;
			MISO_OE <= 1'b0;
			SCK_OE <= 1'b0;
			MOSI_OE <= 1'b0;
		end
		else
		begin
			sck_d_r <= sck_s;
			SCK_OE <= port_en & master;
			MOSI_OE <= port_en & master;
			MISO_OE <= s_active;
			if (!s_active)
			begin
				bit_cnt_r <= 3'h0;
				slv_loaded_r <= 1'b0;
			end
			else if (s_take)
			begin
				slv_loaded_r <= 1'b1;
				MISO_O <= tx_empty_r ? 1'b0 : tx_buf_r[7];
			end
			else if (sck_rise)
			begin
				bit_cnt_r <= bit_cnt_r + 3'h1;
				if (bit_cnt_r == LAST_BIT)
					slv_loaded_r <= 1'b0;
			end
			else if (sck_fall)
				MISO_O <= shift_r[6];
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// status flags; a hardware set always beats the software clear sequence

	always_ff @(posedge CORE_CLK or negedge RSTN)
	begin
		if (!RSTN)
		begin
			rx_flag_r <= 1'b0;
			rx_arm_r <= 1'b0;
			rx_buf_r <= 8'h00;
			tx_empty_r <= 1'b1;
			tx_arm_r <= 1'b0;
			tx_buf_r <= 8'h00;
			mode_fault_flag_r <= 1'b0;
			mode_fault_flag_arm_r <= 1'b0;
		end
		else
		begin
			// an unserviced flag keeps the first byte; later bytes are lost
			if (byte_done && !rx_flag_r)
				rx_buf_r <= byte_in;
			if (byte_done)
				rx_flag_r <= 1'b1; // RQ4
			else if (rd_data && rx_arm_r)
				rx_flag_r <= 1'b0; // RQ5
			if (rd_stat && rx_flag_r)
				rx_arm_r <= 1'b1;
			else if (rd_data)
				rx_arm_r <= 1'b0;

			if (m_take || (s_take && !tx_empty_r))
				tx_empty_r <= 1'b1;
			else if (tx_load)
				tx_empty_r <= 1'b0; // RQ7
			if (tx_load)
				tx_buf_r <= WDATA;
			if (rd_stat && tx_empty_r)
				tx_arm_r <= 1'b1;
			else if (wr_data)
				tx_arm_r <= 1'b0; // RQ8

			if (mode_fault_flag_hit)
				mode_fault_flag_r <= 1'b1; // RQ9
			else if (wr_c1 && mode_fault_flag_arm_r)
				mode_fault_flag_r <= 1'b0; // RQ10
			if (rd_stat && mode_fault_flag_r)
				mode_fault_flag_arm_r <= 1'b1;
			else if (wr_c1)
				mode_fault_flag_arm_r <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// interrupt events share the status bit layout

	logic [7:0] evt_set;

	always_comb
	begin
		evt_set = 8'h00;
		evt_set[BIT_RXC] = byte_done;
		evt_set[BIT_TXE] = m_take | (s_take & ~tx_empty_r);
		evt_set[BIT_MODE_FAULT_FLAG] = mode_fault_flag_hit & ~mode_fault_flag_r;
	end

	always_ff @(posedge CORE_CLK or negedge RSTN)
	begin
		if (!RSTN)
		begin
			evt_r <= 8'h00;
			IRQ <= 1'b0;
		end
		else
		begin
			evt_r <= (evt_r & ~(wr_evt_clr ? WDATA : 8'h00)) | evt_set;
			IRQ <= ctrl1_r[BIT_IRQ_EN] & ((evt_r & evt_en_r) != 8'h00); // RQ14
		end
	end

endmodule
`default_nettype wire

// ===== testbench/spi_flags_chk_sva.sv
`timescale 1ns/10ps
`default_nettype none
module spi_flags_chk
	import spi_flags_pkg::*;
(
	input wire logic CORE_CLK,
	input wire logic RSTN,
	input wire logic [spi_flags_pkg::ADDR_W-1:0] ADDR,
	input wire logic [spi_flags_pkg::DATA_W-1:0] WDATA,
	input wire logic WR,
	input wire logic RD,
	input wire logic [spi_flags_pkg::DATA_W-1:0] RDATA,
	input wire logic IRQ,
	input wire logic SCK_O,
	input wire logic SCK_OE,
	input wire logic MISO_OE,
	input wire logic SS_N_I
);
	default clocking @(posedge CORE_CLK); endclocking
	default disable iff (!RSTN);
	////////////////////////////////////////
	// shadow copies of the fields that the checks depend on
	logic irq_en_r, mode_fault_detect_enable_r;
	logic [7:0] baud_r;
	logic [10:0] hi_r;
	wire [10:0] half = ({8'h00, baud_r[6:4]} + 11'h001) << baud_r[2:0];
	always_ff @(posedge CORE_CLK or negedge RSTN)
		if (!RSTN)
			baud_r <= 8'h00;
		else if (WR && ADDR == OFS_BAUD)
			baud_r <= WDATA;
	always_ff @(posedge CORE_CLK or negedge RSTN)
		if (!RSTN)
			irq_en_r <= 1'b0;
		else if (WR && ADDR == OFS_CTRL1)
			irq_en_r <= WDATA[7];
	always_ff @(posedge CORE_CLK or negedge RSTN)
		if (!RSTN)
			mode_fault_detect_enable_r <= 1'b0;
		else if (WR && ADDR == OFS_CTRL2)
			mode_fault_detect_enable_r <= WDATA[4];
	always_ff @(posedge CORE_CLK or negedge RSTN)
		if (!RSTN)
			hi_r <= 11'h000;
		else
			hi_r <= SCK_O ? hi_r + 11'h001 : 11'h000;
	////////////////////////////////////////
	AST_UNUSED_ZERO:
	assert property ($past(RD) && $past(ADDR) == OFS_STATUS |-> RDATA[6] == 1'b0 && RDATA[3:0] == 4'h0)
		else $error("status unused bits not zero");
	AST_RDATA_IDLE:
	assert property (!$past(RD) |-> RDATA == 8'h00)
		else $error("read data outside read slot");
	AST_UNMAPPED:
	assert property ($past(RD) && ($past(ADDR) == 4'h4 || $past(ADDR) == OFS_EVT_CLR || $past(ADDR) > OFS_EVT_EN)
		|-> RDATA == 8'h00)
		else $error("unmapped read not zero");
	// writes may abort or retime a half period, so those are skipped
	AST_SCK_HALF:
	assert property ($fell(SCK_O) && SCK_OE && !$past(WR) && !$past(WR, 2) && !$past(WR, 3) |-> hi_r == half)
		else $error("serial clock high phase wrong length");
	AST_MODE_FAULT_FLAG_DROP:
	assert property ((mode_fault_detect_enable_r && !SS_N_I) [*8] |-> !SCK_OE)
		else $error("master kept despite select low");
	AST_IRQ_GATE:
	assert property (IRQ |-> irq_en_r || $past(irq_en_r))
		else $error("interrupt without enable");
	AST_ROLE_EXCL:
	assert property (MISO_OE |-> !SCK_OE)
		else $error("master and slave drive at once");
	AST_MISO_HIZ:
	assert property (SS_N_I [*8] |-> !MISO_OE)
		else $error("slave output driven while deselected");
endmodule
bind spi_baud_and_status_flags spi_flags_chk chk_u (.CORE_CLK(CORE_CLK), .RSTN(RSTN), .ADDR(ADDR), .WDATA(WDATA),
	.WR(WR), .RD(RD), .RDATA(RDATA), .IRQ(IRQ), .SCK_O(SCK_O), .SCK_OE(SCK_OE), .MISO_OE(MISO_OE), .SS_N_I(SS_N_I));
`default_nettype wire

// ===== testbench/spi_far_slave.sv
`timescale 1ns/10ps
`default_nettype none
module spi_far_slave
(
	input wire logic sck,
	input wire logic mosi,
	input wire logic sel_n,
	input wire logic [7:0] reply,
	output logic miso,
	output logic [7:0] got
);
	logic [7:0] tx_r;
	logic last_r;
	// a released line shows the inverse of its last bit, never a stale copy
	assign miso = sel_n ? ~last_r : tx_r[7];
	always @(posedge sck)
		if (!sel_n)
			got <= {got[6:0], mosi};
	always @(negedge sck or posedge sel_n)
		if (sel_n)
			tx_r <= reply;
		else
			tx_r <= {tx_r[6:0], 1'b0};
	always @(posedge sel_n)
		last_r <= tx_r[7];
endmodule
`default_nettype wire

// ===== testbench/spi_baud_and_status_flags_bench.sv
`timescale 1ns/10ps
`default_nettype none
module spi_baud_and_status_flags_bench;
	import spi_flags_pkg::*;
	logic CORE_CLK, RSTN, WR, RD, SS_N_I, sel_n, IRQ, SCK_O, SCK_OE, MOSI_O, MISO_I, SCK_I, MOSI_I, MISO_O, MOSI_OE;
	logic [3:0] ADDR;
	logic [7:0] WDATA, RDATA, reply, got, v, q;
	int bad_count, compares, cyc, n1, n2;
	spi_baud_and_status_flags dut_u (.CORE_CLK(CORE_CLK), .RSTN(RSTN), .ADDR(ADDR), .WDATA(WDATA), .WR(WR),
		.RD(RD), .RDATA(RDATA), .IRQ(IRQ), .SCK_O(SCK_O), .SCK_OE(SCK_OE), .SCK_I(SCK_I), .MOSI_O(MOSI_O),
		.MOSI_OE(MOSI_OE), .MOSI_I(MOSI_I), .MISO_O(MISO_O), .MISO_OE(), .MISO_I(MISO_I), .SS_N_I(SS_N_I));
	spi_far_slave far_u (.sck(SCK_O), .mosi(MOSI_O), .sel_n(sel_n), .reply(reply), .miso(MISO_I), .got(got));
	initial
	begin
		CORE_CLK = 1'b0;
		forever #2 CORE_CLK = ~CORE_CLK;
	end
	always @(posedge CORE_CLK)
	begin
		cyc++;
		if (cyc == 60000)
		begin
			bad_count++;
			conclude();
		end
	end
	////////////////////////////////////////
	task automatic conclude();
		$display("compares %0d mismatches %0d", compares, bad_count);
		if (bad_count == 0 && compares > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task automatic chk(input string s, input logic [11:0] e, input logic [11:0] g);
		compares++;
		if (g !== e)
		begin
			bad_count++;
			$display("wrong value %s expected %h seen %h", s, e, g);
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge CORE_CLK);
		WR <= 1'b1;
		ADDR <= a;
		WDATA <= d;
		@(posedge CORE_CLK);
		WR <= 1'b0;
	endtask
	task automatic rd(input logic [3:0] a, output logic [7:0] d);
		@(posedge CORE_CLK);
		RD <= 1'b1;
		ADDR <= a;
		@(posedge CORE_CLK);
		RD <= 1'b0;
		#1 d = RDATA;
	endtask
	task automatic rdc(input string s, input logic [3:0] a, input logic [7:0] e);
		rd(a, v);
		chk(s, {4'h0, e}, {4'h0, v});
	endtask
	task automatic wait_sck(input logic l, output int n);
		n = 0;
		while (SCK_O !== l && n < 20000)
		begin
			@(posedge CORE_CLK);
			#1 n++;
		end
	endtask
	task automatic pin(input string s, input logic e, input logic g);
		chk(s, {11'h000, e}, {11'h000, g});
	endtask
	// the master has no select output, so the bench reselects the far slave per byte
	task automatic arm_slave(input logic [7:0] r);
		reply = r;
		sel_n = 1'b0;
		#1 sel_n = 1'b1;
		#1 sel_n = 1'b0;
	endtask
	task automatic finish(input logic [7:0] t, input logic [7:0] r);
		v = 8'h00;
		while (v[7] !== 1'b1 && cyc < 59000)
			rd(OFS_STATUS, v);
		rdc("rx data", OFS_DATA, r);
		rdc("rx flag cleared", OFS_STATUS, 8'h20);
		chk("slave got", {4'h0, t}, {4'h0, got});
	endtask
	task automatic xfer(input logic [7:0] b, input logic [7:0] t, input logic [7:0] r);
		arm_slave(r);
		wr(OFS_BAUD, b);
		rdc("tx empty", OFS_STATUS, 8'h20);
		wr(OFS_DATA, t);
		wait_sck(1'b1, n1);
		wait_sck(1'b0, n1);
		wait_sck(1'b1, n2);
		chk("divisor", ({9'h000, b[6:4]} + 12'h001) << b[2:0] << 1, 12'(n1 + n2));
		finish(t, r);
	endtask
	// outside master for the slave: seventeen bus clocks per serial clock, far from half rate
	task automatic drive_slave(input logic [7:0] m, output logic [7:0] s);
		@(posedge CORE_CLK);
		SS_N_I <= 1'b0;
		for (int i = 7; i >= 0; i--)
		begin
			MOSI_I <= m[i];
			repeat (8) @(posedge CORE_CLK);
			#1 s[i] = MISO_O;
			@(posedge CORE_CLK);
			SCK_I <= 1'b1;
			repeat (8) @(posedge CORE_CLK);
			SCK_I <= 1'b0;
		end
		repeat (8) @(posedge CORE_CLK);
		SS_N_I <= 1'b1;
	endtask
	////////////////////////////////////////
	initial
	begin
		{RSTN, WR, RD, ADDR, WDATA, reply, bad_count, compares, cyc} = '0;
		SS_N_I = 1'b1;
		SCK_I = 1'b0;
		MOSI_I = 1'b0;
		sel_n = 1'b1;
		repeat (20) @(posedge CORE_CLK);
		RSTN <= 1'b1;
		wr(OFS_DATA, 8'h11);
		rdc("unarmed write", OFS_STATUS, 8'h20);
		rdc("ctrl1", OFS_CTRL1, 8'h00);
		rdc("evt enable", OFS_EVT_EN, 8'hB0);
		rdc("unmapped", 4'h4, 8'h00);
		rdc("unmapped", 4'hF, 8'h00);
		wr(OFS_STATUS, 8'hFF);
		rdc("status write", OFS_STATUS, 8'h20);
		wr(OFS_DATA, 8'h5A);
		rdc("tx loaded", OFS_STATUS, 8'h00);
		$display("registers done");
		arm_slave(8'h3C);
		// the filtered data-in pin lags about four clocks, so the fastest rates cannot sample it
		wr(OFS_BAUD, 8'h03);
		wr(OFS_CTRL1, 8'h50);
		finish(8'h5A, 8'h3C);
		pin("mosi drive", 1'b1, MOSI_OE);
		xfer(8'h77, 8'hC3, 8'h96);
		xfer(8'h12, 8'h81, 8'h7E);
		$display("transfers done");
		wr(OFS_BAUD, 8'h07);
		rd(OFS_STATUS, v);
		wr(OFS_DATA, 8'hA5);
		repeat (100) @(posedge CORE_CLK);
		wr(OFS_BAUD, 8'h06);
		repeat (3000) @(posedge CORE_CLK);
		#1 pin("sck idle", 1'b0, SCK_O);
		rdc("no rx after abort", OFS_STATUS, 8'h20);
		$display("abort done");
		wr(OFS_CTRL2, 8'h10);
		wr(OFS_EVT_CLR, 8'hFF);
		wr(OFS_CTRL1, 8'hD0);
		repeat (3) @(posedge CORE_CLK);
		#1 pin("irq idle", 1'b0, IRQ);
		@(posedge CORE_CLK);
		SS_N_I <= 1'b0;
		repeat (10) @(posedge CORE_CLK);
		#1 pin("irq on fault", 1'b1, IRQ);
		@(posedge CORE_CLK);
		SS_N_I <= 1'b1;
		rdc("master dropped", OFS_CTRL1, 8'hC0);
		wr(OFS_CTRL1, 8'hC0);
		rdc("fault kept", OFS_STATUS, 8'h30);
		wr(OFS_CTRL1, 8'hC0);
		rdc("fault cleared", OFS_STATUS, 8'h20);
		wr(OFS_EVT_EN, 8'h00);
		repeat (2) @(posedge CORE_CLK);
		#1 pin("irq masked", 1'b0, IRQ);
		wr(OFS_EVT_EN, 8'h10);
		repeat (2) @(posedge CORE_CLK);
		#1 pin("irq unmasked", 1'b1, IRQ);
		wr(OFS_EVT_CLR, 8'h10);
		repeat (2) @(posedge CORE_CLK);
		#1 pin("irq cleared", 1'b0, IRQ);
		$display("mode fault done");
		rd(OFS_STATUS, v);
		wr(OFS_DATA, 8'h69);
		#1 pin("mosi drive off", 1'b0, MOSI_OE);
		drive_slave(8'hB4, q);
		rdc("slave status", OFS_STATUS, 8'hA0);
		rdc("slave rx", OFS_DATA, 8'hB4);
		chk("slave sent", {4'h0, 8'h69}, {4'h0, q});
		$display("slave done");
		conclude();
	end
endmodule
`default_nettype wire
